// ---- dv/scc_top_tb.sv ----
// self-checking testbench of the system clock source control block
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, (got), (exp)); end end

module scc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] init_cfg, clk_switch_target, active_source, frc_divide_select;
  logic [1:0] sm_cfg;
  logic usb_en, wait_exec, clk_switch_req, sys_pll_enable, sleep_req, idle_req;
  logic [4:0] pll_factor;
  scc_clk_in_t clk_in;
  int fails, n_checks;

  scc_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .initial_oscillator_config(init_cfg), .switch_monitor_config(sm_cfg),
    .usb_pll_enable(usb_en), .clk_in(clk_in), .wait_exec(wait_exec),
    .clk_switch_req(clk_switch_req), .clk_switch_target(clk_switch_target),
    .active_source(active_source), .pll_factor(pll_factor),
    .frc_divide_select(frc_divide_select), .sys_pll_enable(sys_pll_enable),
    .sleep_req(sleep_req), .idle_req(idle_req));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic do_reset(input logic [2:0] cfg);
    @(posedge clk);
    nrst <= 1'b0;
    init_cfg <= cfg;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  task automatic unlock();
    wr(UNLOCK_KEY_OFFSET, UNLOCK_KEY_FIRST);
    wr(UNLOCK_KEY_OFFSET, UNLOCK_KEY_SECOND);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values(input logic [2:0] src);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat, ({29'h0, src} << CUR_SRC_LSB) | ({29'h0, src} << REQ_SRC_LSB))
    `CHK(active_source, src)
    // a locked write must be dropped until the key pair is seen again
    wr(OSC_CTRL_OFFSET, 32'h0007_0010);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[18:16], 3'h0)
  endtask

  task automatic t_unlock_map();
    unlock();
    rd(UNLOCK_KEY_OFFSET);
    `CHK(rdat[UNLOCKED_BIT], 1'b1)
    rd(8'h20);
    `CHK(perr, 1'b1)
    `CHK(rdat, 32'h0)
  endtask

  task automatic t_pll_mult();
    logic [4:0] f;
    for (int c = 0; c < 8; c++) begin
      f = (c == 7) ? 5'h18 : 5'(15 + c);
      wr(OSC_CTRL_OFFSET, 32'h8000_8A00 | (32'(c) << 16));
      rd(OSC_CTRL_OFFSET);
      `CHK(rdat, 32'h0000_2200 | (32'(c) << 16))
      `CHK(pll_factor, f)
    end
  endtask

  task automatic t_switch();
    int n;
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[SYS_LOCK_BIT], 1'b0)
    clk_in.sys_pll_locked <= 1'b0;
    wr(OSC_CTRL_OFFSET, 32'h0000_0100);
    for (n = 0; n < 20 && clk_switch_req !== 1'b1; n++) @(negedge clk);
    `CHK(clk_switch_target, 3'h1)
    `CHK(active_source, 3'h2)
    @(posedge clk) clk_in.switch_ack <= 1'b1;
    for (n = 0; n < 20 && active_source !== 3'h1; n++) @(negedge clk);
    `CHK(active_source, 3'h1)
    `CHK(clk_switch_req, 1'b0)
    @(posedge clk) clk_in.switch_ack <= 1'b0;
    @(negedge clk);
    `CHK(sys_pll_enable, 1'b1)
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[14:12], 3'h1)
    `CHK(rdat[SYS_LOCK_BIT], 1'b0)
    clk_in.sys_pll_locked <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[SYS_LOCK_BIT], 1'b1)
  endtask

  task automatic t_usb_lock();
    // drop the lock pin well before enabling, so the two-flop delay has settled
    clk_in.usb_pll_locked <= 1'b0;
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[USB_LOCK_BIT], 1'b0)
    usb_en <= 1'b1;
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[USB_LOCK_BIT], 1'b0)
    repeat (110) @(posedge clk);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[USB_LOCK_BIT], 1'b1)
    usb_en <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[USB_LOCK_BIT], 1'b0)
  endtask

  task automatic t_wait_modes();
    for (int s = 0; s < 2; s++) begin
      wr(OSC_CTRL_OFFSET, 32'h0000_0100 | (32'(s) << SLEEP_EN_BIT));
      @(posedge clk) wait_exec <= 1'b1;
      @(posedge clk) wait_exec <= 1'b0;
      @(negedge clk);
      `CHK(sleep_req, 1'(s))
      `CHK(idle_req, 1'(1 - s))
      @(negedge clk);
      `CHK(sleep_req | idle_req, 1'b0)
    end
  endtask

  task automatic t_clock_fail();
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[CLK_FAIL_BIT], 1'b0)
    clk_in.clock_fail_detect <= 1'b1;
    repeat (4) @(posedge clk);
    clk_in.clock_fail_detect <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[CLK_FAIL_BIT], 1'b1)
    wr(OSC_CTRL_OFFSET, 32'h0000_0100);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[CLK_FAIL_BIT], 1'b0)
  endtask

  task automatic t_sel_lock();
    @(posedge clk) sm_cfg <= 2'b10;
    wr(OSC_CTRL_OFFSET, 32'h0000_0180);
    wr(OSC_CTRL_OFFSET, 32'h0006_0280);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[18:16], 3'h0)
    `CHK(rdat[10:8], 3'h1)
    `CHK(clk_switch_req, 1'b0)
    @(posedge clk) sm_cfg <= 2'b00;
    wr(OSC_CTRL_OFFSET, 32'h0306_0180);
    rd(OSC_CTRL_OFFSET);
    `CHK(rdat[18:16], 3'h6)
    `CHK(rdat[26:24], 3'h3)
    `CHK(frc_divide_select, 3'h3)
    `CHK(pll_factor, 5'h15)
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    // whole sequence needs well under 2000 cycles
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    init_cfg = 3'h2;
    sm_cfg = 2'b00;
    usb_en = 1'b0;
    wait_exec = 1'b0;
    clk_in = '0;
    clk_in.sys_pll_locked = 1'b1;
    clk_in.usb_pll_locked = 1'b1;
    fails = 0;
    n_checks = 0;
    do_reset(3'h2);
    t_reset_values(3'h2);
    t_unlock_map();
    t_pll_mult();
    t_switch();
    t_usb_lock();
    t_wait_modes();
    t_clock_fail();
    t_sel_lock();
    // a second reset in mid-run, also clearing the selection lock
    do_reset(3'h5);
    t_reset_values(3'h5);
    summarize();
  end
endmodule

// ---- logic/scc_lock_status.sv ----
// pll lock status: locked, or start-up timer expired, and only while the pll runs
module scc_lock_status
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pll_enable,
  input wire logic pll_locked,
  output logic lock_status
);
  logic [STARTUP_CNT_W-1:0] startup_cnt;
  logic timer_done;

  assign timer_done = (startup_cnt == STARTUP_LAST);

  // timer restarts whenever the pll is switched off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startup_cnt <= '0;
    end else if (!pll_enable) begin
      startup_cnt <= '0;
    end else if (!timer_done) begin
      startup_cnt <= startup_cnt + STARTUP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_status <= 1'b0;
    end else begin
      lock_status <= pll_enable && (pll_locked || timer_done);
    end
  end

  a_disabled_clear: assert property (@(posedge clk) disable iff (!nrst)
    !pll_enable |=> !lock_status)
    else $error("lock status high while pll disabled");
  a_timer_grants: assert property (@(posedge clk) disable iff (!nrst)
    pll_enable && timer_done |=> lock_status)
    else $error("lock status low after start-up timer expired");
endmodule

// ---- logic/scc_pkg.sv ----
// shared constants, types and field layout of the system clock source control block
package scc_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OSC_CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] UNLOCK_KEY_OFFSET = 8'h10;
  localparam logic [31:0] UNLOCK_KEY_FIRST = 32'hAA996655;
  localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h556699AA;

  // ----------------------------------------------------------------
  // oscillator_control field positions
  // ----------------------------------------------------------------
  localparam int FRC_DIV_LSB = 24;
  localparam int PLL_MULT_LSB = 16;
  localparam int CUR_SRC_LSB = 12;
  localparam int REQ_SRC_LSB = 8;
  localparam int SEL_LOCK_BIT = 7;
  localparam int USB_LOCK_BIT = 6;
  localparam int SYS_LOCK_BIT = 5;
  localparam int SLEEP_EN_BIT = 4;
  localparam int CLK_FAIL_BIT = 3;
  localparam int UNLOCKED_BIT = 0;

  // ----------------------------------------------------------------
  // clock source codes and pll factors
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] MULT_CODE_TOP = 3'h7;
  localparam logic [4:0] MULT_FACTOR_BASE = 5'h0F;
  localparam logic [4:0] MULT_FACTOR_TOP = 5'h18;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PLL_STARTUP_NS = 2000;
  localparam int PLL_STARTUP_CYC = (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CNT_W = $clog2(PLL_STARTUP_CYC + 1);
  localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST = STARTUP_CNT_W'(PLL_STARTUP_CYC);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] fast_rc_divider;
    logic [2:0] pll_multiplier_select;
    logic [2:0] current_source_field;
    logic [2:0] requested_source_field;
    logic selection_lock_bit;
    logic sleep_enable_bit;
    logic clock_fail_flag;
  } scc_ctrl_t;

  typedef struct packed {
    logic sys_pll_locked;
    logic usb_pll_locked;
    logic clock_fail_detect;
    logic switch_ack;
  } scc_clk_in_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_REQ = 2'b01,
    SW_RELEASE = 2'b11
  } scc_sw_state_t;

endpackage

// ---- logic/scc_sync.sv ----
// two flip-flop synchroniser for a vector of independent levels
module scc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- logic/scc_top.sv ----
// system clock source control: oscillator control register, unlock, source switch
// Operation
// - pll multiplier code 0 to 6 gives factors 15 to 21 and code 7 gives 24.
// - the current-source field reports the active clock with the eight-code encoding.
// - the requested-source field holds the source to switch to, same encoding.
// - any reset loads the requested source from the initial oscillator configuration.
// - with switch-monitor config 1x, a set selection lock freezes source and pll selections.
// - with switch-monitor config 0x, selections are never locked.
// - usb pll lock status is 1 when locked or timer elapsed, 0 otherwise or when disabled.
// - system pll lock status is 1 when locked or timer elapsed, 0 otherwise or when disabled.
// - sleep enable picks sleep (1) or idle (0) when a wait instruction executes.
// - clock fail flag is set when the fail-safe monitor detects a clock failure.
// - unimplemented bits of the control register read zero and ignore writes.
// - the control register accepts writes only after the unlock sequence.
//
// The APB register port and the register offsets were chosen for this implementation.
module scc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] initial_oscillator_config,
  input wire logic [1:0] switch_monitor_config,
  input wire logic usb_pll_enable,
  input wire scc_pkg::scc_clk_in_t clk_in,
  input wire logic wait_exec,
  output logic clk_switch_req,
  output logic [2:0] clk_switch_target,
  output logic [2:0] active_source,
  output logic [4:0] pll_factor,
  output logic [2:0] frc_divide_select,
  output logic sys_pll_enable,
  output logic sleep_req,
  output logic idle_req
);
  import scc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  scc_ctrl_t ctrl;
  scc_clk_in_t clk_sync;
  scc_sw_state_t sw_state;
  logic loaded;
  logic key_stage;
  logic unlocked;
  logic usb_lock_st;
  logic sys_lock_st;
  logic sel_locked;
  logic setup_phase;
  logic access_wr;
  logic hit_ctrl;
  logic hit_key;
  logic ctrl_wr;
  logic key_wr;
  logic [31:0] next_rdata;

  function automatic logic [4:0] mult_factor(input logic [2:0] code);
    if (code == MULT_CODE_TOP) begin
      return MULT_FACTOR_TOP;
    end
    return MULT_FACTOR_BASE + {2'b00, code};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and lock status
  // ----------------------------------------------------------------
  scc_sync #(.WIDTH($bits(scc_clk_in_t))) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(clk_in),
    .sync_out(clk_sync)
  );

  // the pll only runs while the active source goes through it
  assign sys_pll_enable = (ctrl.current_source_field == SRC_FRC_PLL) ||
                          (ctrl.current_source_field == SRC_PRI_PLL);

  scc_lock_status u_sys_lock (
    .clk(clk),
    .nrst(nrst),
    .pll_enable(sys_pll_enable),
    .pll_locked(clk_sync.sys_pll_locked),
    .lock_status(sys_lock_st)
  );

  scc_lock_status u_usb_lock (
    .clk(clk),
    .nrst(nrst),
    .pll_enable(usb_pll_enable),
    .pll_locked(clk_sync.usb_pll_locked),
    .lock_status(usb_lock_st)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign hit_ctrl = (paddr == OSC_CTRL_OFFSET);
  assign hit_key = (paddr == UNLOCK_KEY_OFFSET);
  assign pslverr = psel && penable && !hit_ctrl && !hit_key;
  assign ctrl_wr = access_wr && hit_ctrl && unlocked;
  assign key_wr = access_wr && hit_key;
  assign sel_locked = switch_monitor_config[1] && ctrl.selection_lock_bit;

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  // any other value on the key register relocks, so a stray write is safe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_stage <= 1'b0;
      unlocked <= 1'b0;
    end else if (key_wr) begin
      key_stage <= (pwdata == UNLOCK_KEY_FIRST);
      unlocked <= key_stage && (pwdata == UNLOCK_KEY_SECOND);
    end
  end

  // ----------------------------------------------------------------
  // oscillator control register
  // ----------------------------------------------------------------
  // configuration is static fuse data, caught on the first edge after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl.requested_source_field <= '0;
      ctrl.pll_multiplier_select <= '0;
    end else if (!loaded) begin
      ctrl.requested_source_field <= initial_oscillator_config;
    end else if (ctrl_wr && !sel_locked) begin
      ctrl.requested_source_field <= pwdata[REQ_SRC_LSB +: 3];
      ctrl.pll_multiplier_select <= pwdata[PLL_MULT_LSB +: 3];
    end
  end

  // lock can only be released by reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl.selection_lock_bit <= 1'b0;
      ctrl.sleep_enable_bit <= 1'b0;
      ctrl.fast_rc_divider <= '0;
    end else if (ctrl_wr) begin
      ctrl.selection_lock_bit <= ctrl.selection_lock_bit || pwdata[SEL_LOCK_BIT];
      ctrl.sleep_enable_bit <= pwdata[SLEEP_EN_BIT];
      if (!sel_locked) begin
        ctrl.fast_rc_divider <= pwdata[FRC_DIV_LSB +: 3];
      end
    end
  end

  // a failure in the same cycle as a clearing write wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl.clock_fail_flag <= 1'b0;
    end else if (clk_sync.clock_fail_detect) begin
      ctrl.clock_fail_flag <= 1'b1;
    end else if (ctrl_wr) begin
      ctrl.clock_fail_flag <= ctrl.clock_fail_flag && pwdata[CLK_FAIL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // clock switch handshake
  // ----------------------------------------------------------------
  // four-phase: request held until ack, then released until ack drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_state <= SW_IDLE;
      clk_switch_target <= '0;
      ctrl.current_source_field <= '0;
    end else if (!loaded) begin
      ctrl.current_source_field <= initial_oscillator_config;
      sw_state <= SW_IDLE;
    end else begin
      case (sw_state)
        SW_IDLE: begin
          if (!sel_locked &&
              ctrl.requested_source_field != ctrl.current_source_field) begin
            clk_switch_target <= ctrl.requested_source_field;
            sw_state <= SW_REQ;
          end
        end
        SW_REQ: begin
          if (clk_sync.switch_ack) begin
            ctrl.current_source_field <= clk_switch_target;
            sw_state <= SW_RELEASE;
          end
        end
        SW_RELEASE: begin
          if (!clk_sync.switch_ack) begin
            sw_state <= SW_IDLE;
          end
        end
        default: begin
          sw_state <= SW_IDLE;
        end
      endcase
    end
  end

  assign clk_switch_req = (sw_state == SW_REQ);
  assign active_source = ctrl.current_source_field;
  assign pll_factor = mult_factor(ctrl.pll_multiplier_select);
  assign frc_divide_select = ctrl.fast_rc_divider;

  // ----------------------------------------------------------------
  // wait instruction
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_req <= 1'b0;
      idle_req <= 1'b0;
    end else begin
      sleep_req <= wait_exec && ctrl.sleep_enable_bit;
      idle_req <= wait_exec && !ctrl.sleep_enable_bit;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured in the setup cycle so prdata comes from a flop with no wait state
  always_comb begin
    next_rdata = '0;
    if (hit_ctrl) begin
      next_rdata[FRC_DIV_LSB +: 3] = ctrl.fast_rc_divider;
      next_rdata[PLL_MULT_LSB +: 3] = ctrl.pll_multiplier_select;
      next_rdata[CUR_SRC_LSB +: 3] = ctrl.current_source_field;
      next_rdata[REQ_SRC_LSB +: 3] = ctrl.requested_source_field;
      next_rdata[SEL_LOCK_BIT] = ctrl.selection_lock_bit;
      next_rdata[USB_LOCK_BIT] = usb_lock_st;
      next_rdata[SYS_LOCK_BIT] = sys_lock_st;
      next_rdata[SLEEP_EN_BIT] = ctrl.sleep_enable_bit;
      next_rdata[CLK_FAIL_BIT] = ctrl.clock_fail_flag;
    end else if (hit_key) begin
      next_rdata[UNLOCKED_BIT] = unlocked;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_mult_top: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.pll_multiplier_select == MULT_CODE_TOP |-> pll_factor == MULT_FACTOR_TOP)
    else $error("top multiplier code does not give its factor");
  a_init_load: assert property (@(posedge clk) disable iff (!nrst)
    $rose(loaded) |-> ctrl.requested_source_field == $past(initial_oscillator_config))
    else $error("requested source not loaded from configuration");
  a_frozen_sel: assert property (@(posedge clk) disable iff (!nrst)
    loaded && sel_locked |=> $stable(ctrl.requested_source_field) &&
    $stable(ctrl.pll_multiplier_select))
    else $error("locked selection changed");
  a_never_lock: assert property (@(posedge clk) disable iff (!nrst)
    loaded && !switch_monitor_config[1] && ctrl_wr |=>
    ctrl.requested_source_field == $past(pwdata[REQ_SRC_LSB +: 3]))
    else $error("selection write dropped while switching enabled");
  a_write_gate: assert property (@(posedge clk) disable iff (!nrst)
    loaded && access_wr && hit_ctrl && !unlocked |=>
    $stable(ctrl.sleep_enable_bit) && $stable(ctrl.requested_source_field))
    else $error("control write accepted without unlock");
  a_fail_sets: assert property (@(posedge clk) disable iff (!nrst)
    clk_sync.clock_fail_detect |=> ctrl.clock_fail_flag [*2])
    else $error("clock fail flag not set and held");
  a_wait_mode: assert property (@(posedge clk) disable iff (!nrst)
    wait_exec |=> (sleep_req == $past(ctrl.sleep_enable_bit)) && (idle_req != sleep_req))
    else $error("wrong low-power state for wait");
  a_switch_done: assert property (@(posedge clk) disable iff (!nrst)
    sw_state == SW_REQ && clk_sync.switch_ack |=>
    ctrl.current_source_field == $past(clk_switch_target) ##1
    ctrl.current_source_field == $past(clk_switch_target, 2))
    else $error("current source not updated on switch completion");
  a_reserved_read: assert property (@(posedge clk) disable iff (!nrst)
    psel && penable && !pwrite && hit_ctrl |->
    prdata[15] == 1'b0 && prdata[11] == 1'b0 && prdata[2:0] == 3'h0 && prdata[31:27] == 5'h00)
    else $error("unimplemented control bit reads nonzero");

  c_switch: cover property (@(posedge clk) disable iff (!nrst)
    sw_state == SW_REQ ##1 sw_state == SW_RELEASE);
  c_unlock: cover property (@(posedge clk) disable iff (!nrst) $rose(unlocked));
  c_fail: cover property (@(posedge clk) disable iff (!nrst) $rose(ctrl.clock_fail_flag));
  c_locked_wr: cover property (@(posedge clk) disable iff (!nrst) ctrl_wr && sel_locked);
endmodule
